//--- isr_top.sv
// status byte, event register sets, service request and operation complete
// Operation
// - power-on sets standard event bit 7
// - command error sets standard bit 5
// - execution error sets standard bit 4
// - lost query output sets standard bit 2
// - armed operation complete sets bit 0
// - standard event read-clear, enable write/read
// - processor link, calibration set op 7,6
// - tuning idle, new reading set op 5,4
// - ramp finished loops set op 3,2
// - overload, visible alarm set op 1,0
// - operation enable, event, condition commands
// - summary bits follow sources, never latch
// - enabled op/standard events drive bits 7,5
// - bit 4 follows output message available
// - bit 6 is enabled summary OR in status query, request in serial poll
// - enabled summary rise raises service request
// - serial poll clears request, keeps summary
// - no new request until register cleared
// - status query returns byte, clears nothing
// - request enable write and read
// - completion query holds, then replies one
// - clear-status clears both event registers
// - queries return binary-weighted register value
`timescale 1ns/1ns
`include "isr_map.svh"
module isr_top (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // command port from the parser
  input  wire logic                cmd_valid,
  input  wire isr_pkg::isr_cmd_t   cmd_code,
  input  wire logic [7:0]          cmd_data,
  output logic                     cmd_ready,
  // query answers toward the output buffer
  output logic                     rsp_valid,
  output logic [7:0]               rsp_data,
  output logic                     hold_bus,
  // interface events, one-cycle pulses; ops_pending is a level
  input  wire logic                cmd_error,
  input  wire logic                exec_error,
  input  wire logic                query_error,
  input  wire logic                ops_pending,
  // operation conditions, levels
  input  wire logic                comm_loss_flag,
  input  wire logic                cal_error_flag,
  input  wire logic                tuning_idle_flag,
  input  wire logic                new_reading_flag,
  input  wire logic                loop_one_ramp_finished,
  input  wire logic                loop_two_ramp_finished,
  input  wire logic                input_overload_flag,
  input  wire logic                alarm_active,
  input  wire logic                alarm_visible,
  // output buffer state
  input  wire logic                msg_available,
  // serial poll and service request
  input  wire logic                serial_poll,
  output logic                     poll_valid,
  output logic [7:0]               poll_data,
  output logic                     srq
);
  import isr_pkg::*;

  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    logic [7:0] std_enable;
    logic [7:0] op_enable;
    logic [7:0] srq_enable;
    logic [2:0] summ_prev;
    logic       rqs;
    logic       opc_armed;
    logic       opc_wait;
    logic       opc_done;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       poll_valid;
    logic [7:0] poll_data;
  } isr_state_t;

  isr_state_t st;
  isr_state_t next_st;

  logic [7:0] std_flags;
  logic [7:0] op_flags;
  logic [7:0] std_cond;
  logic [7:0] op_cond;
  logic       std_clear;
  logic       op_clear;
  logic       take;
  logic       operation_summary_flag;
  logic       esb;
  logic       mav;
  logic [2:0] summ_en;
  logic [2:0] summ_rise;
  logic       mss;
  logic [7:0] status_byte;

  // ******************************************************************
  // event register sets
  // ******************************************************************
  assign take = cmd_valid & cmd_ready;

  always_comb begin
    std_cond = `ISR_ZERO_BYTE;
    std_cond[`ISR_STD_CME] = cmd_error;
    std_cond[`ISR_STD_EXE] = exec_error;
    std_cond[`ISR_STD_QYE] = query_error;
    std_cond[`ISR_STD_OPC] = st.opc_done;
  end

  always_comb begin
    op_cond = `ISR_ZERO_BYTE;
    op_cond[`ISR_OP_COMM]  = comm_loss_flag;
    op_cond[`ISR_OP_CAL]   = cal_error_flag;
    op_cond[`ISR_OP_TUNE]  = tuning_idle_flag;
    op_cond[`ISR_OP_RDG]   = new_reading_flag;
    op_cond[`ISR_OP_RAMP_ONE] = loop_one_ramp_finished;
    op_cond[`ISR_OP_RAMP_TWO] = loop_two_ramp_finished;
    op_cond[`ISR_OP_OVERLOAD] = input_overload_flag;
    op_cond[`ISR_OP_ALARM] = alarm_active & alarm_visible;
  end

  assign std_clear = take & ((cmd_code == ISR_CMD_ESR_READ) | (cmd_code == ISR_CMD_CLS));
  assign op_clear  = take & ((cmd_code == ISR_CMD_OP_EVENT_READ_CLEAR) | (cmd_code == ISR_CMD_CLS));

  isr_event_reg #(
    .WIDTH       (`ISR_REG_W),
    .RESET_FLAGS (`ISR_STD_RESET)
  ) u_std_events (
    .core_clk (core_clk),
    .rst      (rst),
    .cond     (std_cond),
    .clear    (std_clear),
    .flags    (std_flags)
  );

  isr_event_reg #(
    .WIDTH       (`ISR_REG_W),
    .RESET_FLAGS (`ISR_OP_RESET)
  ) u_op_events (
    .core_clk (core_clk),
    .rst      (rst),
    .cond     (op_cond),
    .clear    (op_clear),
    .flags    (op_flags)
  );

  // ******************************************************************
  // status byte and service request
  // ******************************************************************
  // summaries are combinational
  assign operation_summary_flag = |(op_flags & st.op_enable);
  assign esb = |(std_flags & st.std_enable);
  assign mav = msg_available;

  assign summ_en = {operation_summary_flag & st.srq_enable[`ISR_STB_OP_SUM],
                    esb & st.srq_enable[`ISR_STB_ESB],
                    mav & st.srq_enable[`ISR_STB_MAV]};
  assign mss = |summ_en;
  // a summary already high gives no rise
  assign summ_rise = summ_en & ~st.summ_prev;

  always_comb begin
    status_byte = `ISR_ZERO_BYTE;
    status_byte[`ISR_STB_OP_SUM] = operation_summary_flag;
    status_byte[`ISR_STB_ESB] = esb;
    status_byte[`ISR_STB_MAV] = mav;
  end

  // ******************************************************************
  // command decode and sequencing
  // ******************************************************************
  always_comb begin
    next_st            = st;
    next_st.summ_prev  = summ_en;
    next_st.rsp_valid  = 1'b0;
    next_st.poll_valid = 1'b0;
    next_st.opc_done   = 1'b0;
    // poll clears request only; rise sets, set wins
    next_st.rqs = (st.rqs & ~serial_poll) | (|summ_rise);
    if (serial_poll) begin
      next_st.poll_valid = 1'b1;
      next_st.poll_data  = status_byte;
      next_st.poll_data[`ISR_STB_RQS] = st.rqs;
    end
    // arm clears once nothing is pending
    if (st.opc_armed && !ops_pending) begin
      next_st.opc_armed = 1'b0;
      next_st.opc_done  = 1'b1;
    end
    if (st.opc_wait && !ops_pending) begin
      next_st.opc_wait  = 1'b0;
      next_st.rsp_valid = 1'b1;
      next_st.rsp_data  = `ISR_OPC_REPLY;
    end
    if (take) begin
      // answers are the raw weighted byte
      case (cmd_code)
        ISR_CMD_ESE_WRITE: begin
          next_st.std_enable = cmd_data;
        end
        ISR_CMD_ESE_READ: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.std_enable;
        end
        ISR_CMD_ESR_READ: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = std_flags;
        end
        ISR_CMD_SRE_WRITE: begin
          next_st.srq_enable = cmd_data & `ISR_SRE_WMASK;
        end
        ISR_CMD_SRE_READ: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.srq_enable;
        end
        ISR_CMD_STB_READ: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = status_byte;
          next_st.rsp_data[`ISR_STB_RQS] = mss;
        end
        ISR_CMD_CLS: begin
          next_st.opc_armed = 1'b0;
        end
        ISR_CMD_OPC: begin
          next_st.opc_armed = 1'b1;
        end
        ISR_CMD_OPC_QUERY: begin
          next_st.opc_wait = 1'b1;
        end
        ISR_CMD_OP_ENABLE_WRITE: begin
          next_st.op_enable = cmd_data;
        end
        ISR_CMD_OP_ENABLE_READ: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.op_enable;
        end
        ISR_CMD_OP_EVENT_READ_CLEAR: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = op_flags;
        end
        ISR_CMD_OP_CONDITION_READ: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = op_cond;
        end
        default: begin
          next_st.rsp_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  // commands refused while completion query waits
  assign cmd_ready  = ~st.opc_wait;
  assign hold_bus   = st.opc_wait;
  assign rsp_valid  = st.rsp_valid;
  assign rsp_data   = st.rsp_data;
  assign poll_valid = st.poll_valid;
  assign poll_data  = st.poll_data;
  assign srq        = st.rqs;

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_esr_take;
    take && cmd_code == ISR_CMD_ESR_READ && std_cond == `ISR_ZERO_BYTE;
  endsequence

  sequence s_opc_armed_idle;
    st.opc_armed && !ops_pending && !std_clear && !st.opc_done;
  endsequence

  sequence s_poll_quiet;
    serial_poll && summ_rise == 3'h0;
  endsequence

  a_esr_read_clear: assert property (
    s_esr_take |=> rsp_valid && rsp_data == $past(std_flags) && std_flags == `ISR_ZERO_BYTE)
    else $error("standard event read did not return and clear");

  a_esb_drops_clear: assert property (
    s_esr_take ##0 esb |=> !esb)
    else $error("event summary stayed after its register cleared");

  a_srq_on_rise: assert property (
    summ_rise != 3'h0 |=> srq ##0 poll_data[`ISR_STB_RQS] == $past(st.rqs) || !poll_valid)
    else $error("enabled summary rise raised no request");

  a_poll_clears_rqs: assert property (
    s_poll_quiet |=> !srq ##0 poll_valid)
    else $error("serial poll did not clear the request");

  a_mss_survives_poll: assert property (
    s_poll_quiet ##0 mss && !std_clear && !op_clear && !cmd_valid |=> mss || $fell(msg_available))
    else $error("serial poll cleared the master summary");

  a_no_repeat_srq: assert property (
    s_poll_quiet ##0 summ_en != 3'h0 ##1 (summ_en == $past(summ_en)) |-> !srq)
    else $error("request repeated without a register clear");

  a_stb_no_clear: assert property (
    take && cmd_code == ISR_CMD_STB_READ && std_cond == `ISR_ZERO_BYTE && op_cond == `ISR_ZERO_BYTE
      |=> rsp_valid && rsp_data[`ISR_STB_RQS] == $past(mss) && std_flags == $past(std_flags)
      && op_flags == $past(op_flags) && (srq || !$past(srq) || $past(serial_poll)))
    else $error("status query answer wrong");

  a_opc_query_reply: assert property (
    st.opc_wait && !ops_pending |=> rsp_valid && rsp_data == `ISR_OPC_REPLY && !hold_bus)
    else $error("completion query gave no reply of one");

  a_opc_sets_bit0: assert property (
    s_opc_armed_idle |-> ##2 std_flags[`ISR_STD_OPC])
    else $error("operation complete bit not set");

  a_cls_clears_all: assert property (
    take && cmd_code == ISR_CMD_CLS && std_cond == `ISR_ZERO_BYTE && op_cond == `ISR_ZERO_BYTE
      |=> std_flags == `ISR_ZERO_BYTE && op_flags == `ISR_ZERO_BYTE)
    else $error("clear status left events set");

  a_mav_in_stb: assert property (
    take && cmd_code == ISR_CMD_STB_READ |=> rsp_data[`ISR_STB_MAV] == $past(msg_available))
    else $error("message available misreported");

  a_refuse_in_wait: assert property (
    st.opc_wait && ops_pending |-> !cmd_ready && hold_bus)
    else $error("command accepted during completion query");

endmodule : isr_top

//--- isr_map.svh
// bit positions, masks and reset values of the status reporting block
`ifndef ISR_MAP_SVH
`define ISR_MAP_SVH

`define ISR_REG_W          8
`define ISR_ZERO_BYTE      8'h00
`define ISR_OPC_REPLY      8'h01
// standard event bit positions
`define ISR_STD_PON        7
`define ISR_STD_CME        5
`define ISR_STD_EXE        4
`define ISR_STD_QYE        2
`define ISR_STD_OPC        0
`define ISR_STD_RESET      8'h80
// operation event bit positions
`define ISR_OP_COMM        7
`define ISR_OP_CAL         6
`define ISR_OP_TUNE        5
`define ISR_OP_RDG         4
`define ISR_OP_RAMP_ONE    3
`define ISR_OP_RAMP_TWO    2
`define ISR_OP_OVERLOAD    1
`define ISR_OP_ALARM       0
`define ISR_OP_RESET       8'h00
// status byte bit positions
`define ISR_STB_OP_SUM     7
`define ISR_STB_RQS        6
`define ISR_STB_ESB        5
`define ISR_STB_MAV        4
// request enable bit 6 never takes part in the summary
`define ISR_SRE_WMASK      8'hBF

`endif

//--- isr_pkg.sv
// types shared by the status reporting block
package isr_pkg;

  typedef enum logic [3:0] {
    ISR_CMD_ESE_WRITE,
    ISR_CMD_ESE_READ,
    ISR_CMD_ESR_READ,
    ISR_CMD_SRE_WRITE,
    ISR_CMD_SRE_READ,
    ISR_CMD_STB_READ,
    ISR_CMD_CLS,
    ISR_CMD_OPC,
    ISR_CMD_OPC_QUERY,
    ISR_CMD_OP_ENABLE_WRITE,
    ISR_CMD_OP_ENABLE_READ,
    ISR_CMD_OP_EVENT_READ_CLEAR,
    ISR_CMD_OP_CONDITION_READ
  } isr_cmd_t;

endpackage : isr_pkg

//--- isr_event_reg.sv
// edge-latched event register with read-and-clear
`timescale 1ns/1ns
module isr_event_reg #(
  parameter int               WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_FLAGS = '0
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // condition inputs and clear
  input  wire logic [WIDTH-1:0] cond,
  input  wire logic             clear,
  // latched events
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
    logic [WIDTH-1:0] prev;
  } isr_evt_state_t;

  isr_evt_state_t st;
  isr_evt_state_t next_st;

  if (WIDTH < 1) begin : g_chk
    $error("isr_event_reg: WIDTH must be at least 1");
  end

  always_comb begin
    next_st      = st;
    next_st.prev = cond;
    // latch on rise
    // set wins over a clear in the same cycle
    next_st.flags = (clear ? '0 : st.flags) | (cond & ~st.prev);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st.flags <= RESET_FLAGS;
      st.prev  <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.flags;

endmodule : isr_event_reg

//--- isr_ctrl_model.sv
// bus controller model that serial-polls on a service request
`timescale 1ns/1ns
module isr_ctrl_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // host program control
  input  wire logic       auto_poll,
  input  wire logic [3:0] poll_delay,
  // device side
  input  wire logic       srq,
  input  wire logic       poll_valid,
  input  wire logic [7:0] poll_data,
  output logic            serial_poll,
  output logic [7:0]      last_poll,
  output logic [7:0]      poll_count
);
  logic [3:0] wait_cnt;
  logic       busy;
  logic       sent;
  // one poll per request, prompt or slow
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serial_poll <= 1'b0;
      busy        <= 1'b0;
      sent        <= 1'b0;
      wait_cnt    <= 4'h0;
      last_poll   <= 8'h00;
      poll_count  <= 8'h00;
    end else begin
      serial_poll <= 1'b0;
      if (poll_valid) begin
        last_poll  <= poll_data;
        poll_count <= poll_count + 8'h01;
        busy       <= 1'b0;
        sent       <= 1'b0;
      end else if (!busy && auto_poll && srq) begin
        busy     <= 1'b1;
        wait_cnt <= poll_delay;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy && !sent) begin
        serial_poll <= 1'b1;
        sent        <= 1'b1;
      end
    end
  end
endmodule : isr_ctrl_model

//--- instrument_status_reporting_test.sv
// self-checking bench of the status reporting block
`timescale 1ns/1ns
module instrument_status_reporting_test;
  import isr_pkg::*;
  logic       core_clk;
  logic       rst;
  logic       cmd_valid;
  isr_cmd_t   cmd_code;
  logic [7:0] cmd_data;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       hold_bus;
  logic [2:0] evt;
  logic       ops_pending;
  logic [7:0] op_cond;
  logic       alarm_vis;
  logic       msg_available;
  logic       serial_poll;
  logic       poll_valid;
  logic [7:0] poll_data;
  logic       srq;
  logic       auto_poll;
  logic [7:0] last_poll;
  logic [7:0] poll_count;
  int         err_total;
  int         compares;

  isr_top i_isr_top (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .hold_bus(hold_bus), .cmd_error(evt[2]), .exec_error(evt[1]), .query_error(evt[0]),
    .ops_pending(ops_pending), .comm_loss_flag(op_cond[7]), .cal_error_flag(op_cond[6]),
    .tuning_idle_flag(op_cond[5]), .new_reading_flag(op_cond[4]), .loop_one_ramp_finished(op_cond[3]),
    .loop_two_ramp_finished(op_cond[2]), .input_overload_flag(op_cond[1]), .alarm_active(op_cond[0]),
    .alarm_visible(alarm_vis), .msg_available(msg_available), .serial_poll(serial_poll),
    .poll_valid(poll_valid), .poll_data(poll_data), .srq(srq));
  isr_ctrl_model i_isr_ctrl_model (.core_clk(core_clk), .rst(rst), .auto_poll(auto_poll),
    .poll_delay(4'h3), .srq(srq), .poll_valid(poll_valid), .poll_data(poll_data),
    .serial_poll(serial_poll), .last_poll(last_poll), .poll_count(poll_count));

  // ****************************************
  // helpers
  // ****************************************
  always #20 core_clk = ~core_clk;

  task automatic wrap_up();
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cycles

  // command held until an edge samples ready
  task automatic issue(input isr_cmd_t code, input logic [7:0] data);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_data  <= data;
    @(posedge core_clk);
    for (int n = 0; n < 100 && cmd_ready !== 1'b1; n++) @(posedge core_clk);
    chk({7'h00, cmd_ready}, 8'h01);
    cmd_valid <= 1'b0;
  endtask : issue

  task automatic query(input isr_cmd_t code, input logic [7:0] exp);
    issue(code, 8'h00);
    cycles(1);
    chk({7'h00, rsp_valid}, 8'h01);
    chk(rsp_data, exp);
  endtask : query

  task automatic pulse(input logic [2:0] bits);
    @(posedge core_clk);
    evt <= bits;
    @(posedge core_clk);
    evt <= 3'h0;
  endtask : pulse

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    query(ISR_CMD_ESE_READ, 8'h00);
    query(ISR_CMD_SRE_READ, 8'h00);
    query(ISR_CMD_OP_ENABLE_READ, 8'h00);
    query(ISR_CMD_ESR_READ, 8'h80);
    query(ISR_CMD_ESR_READ, 8'h00);
  endtask : t_reset

  task automatic t_errors();
    pulse(3'h7);
    cycles(2);
    query(ISR_CMD_ESR_READ, 8'h34);
  endtask : t_errors

  task automatic t_request();
    issue(ISR_CMD_ESE_WRITE, 8'h20);
    issue(ISR_CMD_SRE_WRITE, 8'hFF);
    query(ISR_CMD_ESE_READ, 8'h20);
    query(ISR_CMD_SRE_READ, 8'hBF);
    pulse(3'h4);
    cycles(12);
    chk(poll_count, 8'h01);
    chk(last_poll, 8'h60);
    chk({7'h00, srq}, 8'h00);
    query(ISR_CMD_STB_READ, 8'h60);
    pulse(3'h4);
    cycles(12);
    chk(poll_count, 8'h01);
    query(ISR_CMD_ESR_READ, 8'h20);
    query(ISR_CMD_STB_READ, 8'h00);
    issue(ISR_CMD_ESE_WRITE, 8'h00);
  endtask : t_request

  task automatic t_operation();
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      op_cond <= 8'h01 << i;
      cycles(2);
      query(ISR_CMD_OP_CONDITION_READ, 8'h01 << i);
      op_cond <= 8'h00;
      query(ISR_CMD_OP_EVENT_READ_CLEAR, 8'h01 << i);
      query(ISR_CMD_OP_EVENT_READ_CLEAR, 8'h00);
    end
    alarm_vis <= 1'b0;
    op_cond   <= 8'h01;
    cycles(3);
    query(ISR_CMD_OP_EVENT_READ_CLEAR, 8'h00);
    op_cond <= 8'h00;
  endtask : t_operation

  task automatic t_summary();
    auto_poll <= 1'b0;
    issue(ISR_CMD_OP_ENABLE_WRITE, 8'h10);
    issue(ISR_CMD_SRE_WRITE, 8'h80);
    query(ISR_CMD_OP_ENABLE_READ, 8'h10);
    op_cond <= 8'h10;
    cycles(6);
    chk({7'h00, srq}, 8'h01);
    query(ISR_CMD_STB_READ, 8'hC0);
    pulse(3'h2);
    issue(ISR_CMD_CLS, 8'h00);
    query(ISR_CMD_STB_READ, 8'h00);
    query(ISR_CMD_ESR_READ, 8'h00);
    op_cond       <= 8'h00;
    msg_available <= 1'b1;
    cycles(2);
    query(ISR_CMD_STB_READ, 8'h10);
    msg_available <= 1'b0;
    query(ISR_CMD_STB_READ, 8'h00);
    auto_poll <= 1'b1;
  endtask : t_summary

  task automatic t_complete();
    ops_pending <= 1'b1;
    issue(ISR_CMD_OPC, 8'h00);
    cycles(4);
    query(ISR_CMD_ESR_READ, 8'h00);
    ops_pending <= 1'b0;
    cycles(4);
    query(ISR_CMD_ESR_READ, 8'h01);
    ops_pending <= 1'b1;
    issue(ISR_CMD_OPC_QUERY, 8'h00);
    cycles(4);
    chk({6'h00, hold_bus, cmd_ready}, 8'h02);
    ops_pending <= 1'b0;
    for (int n = 0; n < 20 && rsp_valid !== 1'b1; n++) cycles(1);
    chk({7'h00, rsp_valid}, 8'h01);
    chk(rsp_data, 8'h01);
    query(ISR_CMD_ESR_READ, 8'h00);
  endtask : t_complete

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    core_clk      = 1'b0;
    rst           = 1'b1;
    cmd_valid     = 1'b0;
    cmd_code      = ISR_CMD_STB_READ;
    cmd_data      = 8'h00;
    evt           = 3'h0;
    ops_pending   = 1'b0;
    op_cond       = 8'h00;
    alarm_vis     = 1'b1;
    msg_available = 1'b0;
    auto_poll     = 1'b1;
    err_total     = 0;
    compares      = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_errors();
    t_request();
    t_operation();
    t_summary();
    t_complete();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    wrap_up();
  end
endmodule : instrument_status_reporting_test
